// ===== rtl/ext_int_pkg.sv
// Package holding register map, field layout and types of the external interrupt latch unit.
package ext_int_pkg;

	localparam int          NUM_CHAN         = 2;
	localparam int          ADDR_W           = 8;
	// Register offsets are word indexes; the byte address is four times the index.
	localparam logic [7:0]  IDX_B_SC         = 8'h1c;
	localparam logic [7:0]  IDX_A_SC         = 8'h1e;
	localparam logic [7:0]  IDX_BREAK_CTRL   = 8'h20;
	localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h21;
	localparam logic [7:0]  IDX_IRQ_MASK     = 8'h22;
	localparam logic [7:0]  IDX_PIN_LEVEL    = 8'h23;
	localparam int          IDX_SHIFT        = 2;

	// Status and control field positions.
	localparam int          BIT_SENSE        = 0;
	localparam int          BIT_MASK         = 1;
	localparam int          BIT_ACK          = 2;
	localparam int          BIT_PEND         = 3;
	localparam int          BIT_PULLUP_DIS   = 4;
	localparam int          BIT_BREAK_CLR_EN = 0;
	localparam int          BIT_IN_BREAK     = 1;

	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	localparam logic [31:0] READ_ZERO        = 32'h0000_0000;
	localparam logic [1:0]  CHAN_ZERO        = 2'h0;

	typedef struct packed {
		logic pullup_dis;
		logic mask;
		logic sense;
	} chan_ctrl_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
		logic [3:0]        strb;
	} wr_req_type;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} wr_state_type;

endpackage

// ===== rtl/ext_int_latch.sv
// Two-channel external interrupt latch unit with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
//
// Notes on behaviour
// (R1) Low pin sets latch; acknowledge or reset clears.
// (R2) Level mode clears after acknowledge and pin high.
// (R3) Vector fetch produces acknowledge clearing latch.
// (R4) Acknowledge bit write-one clears, reads zero.
// (R5) Edge after acknowledge latches fresh request.
// (R6) Acknowledge and pin-high in either order.
// (R7) Reset clears latch and sensitivity bit.
// (R8) Edge mode: acknowledge clears latch immediately.
// (R9) Pending flag reflects latch, ignoring mask.
// (R10) Mask bit blocks request; reset clears mask.
// (R11) Sensitivity bit selects edge or edge-level.
// (R12) First pin level visible to branch logic.
// (R13) First pullup fixed; second pullup disable bit.
// (R14) Break-clear enable lets break acknowledges clear.
// (R15) Break-clear disabled: break acknowledges ignored.
// (R16) Software masks level channel inside handler.
// (R17) Pins pass two flops; falling edge detect.
// (R18) Request is latch and not mask.
module ext_int_latch
	import ext_int_pkg::*;
(
	input  wire logic                           CORE_CLK,        // Bus clock.
	input  wire logic                           RST_N,           // Async reset, active low.
	input  wire logic [ext_int_pkg::NUM_CHAN-1:0] EXT_INT_PIN_N, // Pins, active low, 0=a.
	input  wire logic [ext_int_pkg::NUM_CHAN-1:0] VECTOR_FETCH,  // CPU vector fetch per chan.
	input  wire logic                           BREAK_STATE,     // CPU in break state.
	output logic      [ext_int_pkg::NUM_CHAN-1:0] INT_REQ,       // Unmasked requests to CPU.
	output logic                                PIN_A_LEVEL,     // Pin a level for branches.
	output logic      [ext_int_pkg::NUM_CHAN-1:0] PULLUP_EN,     // Pullup enable per pin.
	output logic                                IRQ,             // Summary interrupt level.
	input  wire logic [ext_int_pkg::ADDR_W-1:0] AWADDR,          // Write address.
	input  wire logic                           AWVALID,         // Write address valid.
	output logic                                AWREADY,         // Write address ready.
	input  wire logic [31:0]                    WDATA,           // Write data.
	input  wire logic [3:0]                     WSTRB,           // Write strobes.
	input  wire logic                           WVALID,          // Write data valid.
	output logic                                WREADY,          // Write data ready.
	output logic [1:0]                          BRESP,           // Write response.
	output logic                                BVALID,          // Write response valid.
	input  wire logic                           BREADY,          // Write response ready.
	input  wire logic [ext_int_pkg::ADDR_W-1:0] ARADDR,          // Read address.
	input  wire logic                           ARVALID,         // Read address valid.
	output logic                                ARREADY,         // Read address ready.
	output logic [31:0]                         RDATA,           // Read data.
	output logic [1:0]                          RRESP,           // Read response.
	output logic                                RVALID,          // Read valid.
	input  wire logic                           RREADY           // Read ready.
);
	import ext_int_pkg::*;

	logic          [NUM_CHAN-1:0] sync1_r;
	logic          [NUM_CHAN-1:0] sync2_r;
	logic          [NUM_CHAN-1:0] prev_r;
	logic          [NUM_CHAN-1:0] latch_r;
	logic          [NUM_CHAN-1:0] latch_nxt;
	logic          [NUM_CHAN-1:0] sense_r;
	logic          [NUM_CHAN-1:0] mask_r;
	logic          [NUM_CHAN-1:0] fall;
	logic          [NUM_CHAN-1:0] sw_ack;
	logic          [NUM_CHAN-1:0] ack_seen_r;
	logic          [NUM_CHAN-1:0] ack_any;
	logic          [NUM_CHAN-1:0] irq_status_r;
	logic          [NUM_CHAN-1:0] irq_mask_r;
	logic          [NUM_CHAN-1:0] status_w1c;
	logic                         pullup_dis_r;
	logic                         settle1_r;
	logic                         settle2_r;
	logic                         break_clr_en_r;
	logic                         aw_held_r;
	logic                         w_held_r;
	wr_req_type                   wr_r;
	wr_state_type                 wr_state_r;
	logic                         wr_fire;
	logic [ADDR_W-1:0]            wr_idx;
	logic [ADDR_W-1:0]            rd_idx;
	logic [31:0]                  rd_data;
	logic                         rd_ok;
	chan_ctrl_type                ctrl_a;
	chan_ctrl_type                ctrl_b;

	// Write address and data may arrive in either order; both are held until paired.
	assign wr_fire = (wr_state_r == WR_IDLE) && (aw_held_r || (AWVALID && AWREADY))
		&& (w_held_r || (WVALID && WREADY));
	assign wr_idx  = wr_r.addr >> IDX_SHIFT;
	assign rd_idx  = ARADDR >> IDX_SHIFT;
	assign ctrl_a  = '{pullup_dis: 1'b0, mask: mask_r[0], sense: sense_r[0]};
	assign ctrl_b  = '{pullup_dis: pullup_dis_r, mask: mask_r[1], sense: sense_r[1]};

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			wr_r      <= '0;
			AWREADY   <= 1'b0;
			WREADY    <= 1'b0;
		end else begin
			AWREADY <= !aw_held_r && !(AWVALID && AWREADY) && (wr_state_r == WR_IDLE);
			WREADY  <= !w_held_r && !(WVALID && WREADY) && (wr_state_r == WR_IDLE);
			if (AWVALID && AWREADY) begin
				wr_r.addr <= AWADDR;
			end
			if (WVALID && WREADY) begin
				wr_r.data <= WDATA;
				wr_r.strb <= WSTRB;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				AWREADY   <= 1'b0;
				WREADY    <= 1'b0;
			end else begin
				if (AWVALID && AWREADY) begin
					aw_held_r <= 1'b1;
				end
				if (WVALID && WREADY) begin
					w_held_r <= 1'b1;
				end
			end
		end
	end

	// The write takes effect one cycle after pairing, from the held copy.
	logic wr_do_r;
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_do_r    <= 1'b0;
			wr_state_r <= WR_IDLE;
			BVALID     <= 1'b0;
			BRESP      <= RESP_OKAY;
		end else begin
			wr_do_r <= wr_fire;
			if (wr_fire) begin
				wr_state_r <= WR_RESP;
			end
			if (wr_do_r) begin
				BVALID <= 1'b1;
				if ((wr_idx == IDX_A_SC) || (wr_idx == IDX_B_SC) || (wr_idx == IDX_BREAK_CTRL)
					|| (wr_idx == IDX_IRQ_STATUS) || (wr_idx == IDX_IRQ_MASK)
					|| (wr_idx == IDX_PIN_LEVEL)) begin
					BRESP <= RESP_OKAY;
				end else begin
					BRESP <= RESP_SLVERR;
				end
			end else if (BVALID && BREADY) begin
				BVALID     <= 1'b0;
				wr_state_r <= WR_IDLE;
			end
		end
	end

	// Software acknowledge strobes, gated by the break interlock.
	always_comb begin
		sw_ack     = CHAN_ZERO;
		status_w1c = CHAN_ZERO;
		if (wr_do_r && wr_r.strb[0]) begin
			// (R14) (R15) break acknowledge gating
			if (!BREAK_STATE || break_clr_en_r) begin
				if (wr_idx == IDX_A_SC) begin
					sw_ack[0] = wr_r.data[BIT_ACK];
				end else if (wr_idx == IDX_B_SC) begin
					sw_ack[1] = wr_r.data[BIT_ACK];
				end
			end
			if (wr_idx == IDX_IRQ_STATUS) begin
				status_w1c = wr_r.data[NUM_CHAN-1:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sense_r        <= CHAN_ZERO;
			mask_r         <= CHAN_ZERO;
			pullup_dis_r   <= 1'b0;
			break_clr_en_r <= 1'b0;
			irq_mask_r     <= CHAN_ZERO;
		end else if (wr_do_r && wr_r.strb[0]) begin
			// (R10) (R11) (R13) control bits
			if (wr_idx == IDX_A_SC) begin
				sense_r[0] <= wr_r.data[BIT_SENSE];
				mask_r[0]  <= wr_r.data[BIT_MASK];
			end else if (wr_idx == IDX_B_SC) begin
				sense_r[1]   <= wr_r.data[BIT_SENSE];
				mask_r[1]    <= wr_r.data[BIT_MASK];
				pullup_dis_r <= wr_r.data[BIT_PULLUP_DIS];
			end else if (wr_idx == IDX_BREAK_CTRL) begin
				break_clr_en_r <= wr_r.data[BIT_BREAK_CLR_EN];
			end else if (wr_idx == IDX_IRQ_MASK) begin
				irq_mask_r <= wr_r.data[NUM_CHAN-1:0];
			end
		end
	end

	// (R17) two-flop synchroniser, edge on second stage
	// The edge history stays low until the synchroniser has flushed its reset value.
	// A pin held low through reset therefore does not fake a falling edge afterwards.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1_r   <= {NUM_CHAN{1'b1}};
			sync2_r   <= {NUM_CHAN{1'b1}};
			prev_r    <= '0;
			settle1_r <= 1'b0;
			settle2_r <= 1'b0;
		end else begin
			sync1_r   <= EXT_INT_PIN_N;
			sync2_r   <= sync1_r;
			settle1_r <= 1'b1;
			settle2_r <= settle1_r;
			prev_r    <= settle2_r ? sync2_r : '0;
		end
	end

	// Per-channel latch: edge sets; level mode also holds while the pin is low.
	genvar g;
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_chan
			assign fall[g]    = prev_r[g] && !sync2_r[g];
			// (R3) vector fetch acknowledge
			assign ack_any[g] = VECTOR_FETCH[g] || sw_ack[g];
			always_comb begin
				latch_nxt[g] = latch_r[g];
				if (sense_r[g]) begin
					// (R2) (R6) clear needs acknowledge and pin high
					if ((ack_any[g] || ack_seen_r[g]) && sync2_r[g]) begin
						latch_nxt[g] = 1'b0;
					end
					// (R11) low level requests
					if (!sync2_r[g]) begin
						latch_nxt[g] = 1'b1;
					end
				end else if (ack_any[g]) begin
					// (R8) edge mode clears at once
					latch_nxt[g] = 1'b0;
				end
				// (R1) (R5) fresh edge wins over acknowledge
				if (fall[g]) begin
					latch_nxt[g] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		// (R7) reset clears latch
		if (!RST_N) begin
			latch_r    <= CHAN_ZERO;
			ack_seen_r <= CHAN_ZERO;
		end else begin
			latch_r    <= latch_nxt;
			ack_seen_r <= (ack_seen_r | ack_any) & latch_nxt & ~fall;
		end
	end

	// Sticky event bits for the summary interrupt; set wins over a same-cycle clear.
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			irq_status_r <= CHAN_ZERO;
			IRQ          <= 1'b0;
		end else begin
			irq_status_r <= (irq_status_r & ~status_w1c) | fall;
			IRQ          <= |(((irq_status_r & ~status_w1c) | fall) & ~irq_mask_r);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			INT_REQ     <= CHAN_ZERO;
			PIN_A_LEVEL <= 1'b1;
			PULLUP_EN   <= {NUM_CHAN{1'b1}};
		end else begin
			// (R18) (R10) masked request
			INT_REQ     <= latch_nxt & ~mask_r;
			// (R12) pin a only
			PIN_A_LEVEL <= sync2_r[0];
			// (R13) pullups
			PULLUP_EN   <= {~pullup_dis_r, 1'b1};
		end
	end

	// Read mux. Acknowledge bits read zero.
	always_comb begin
		rd_data = READ_ZERO;
		rd_ok   = 1'b1;
		if (rd_idx == IDX_A_SC) begin
			// (R9) (R4) pending flag, ack reads zero
			rd_data[BIT_PEND]  = latch_r[0];
			rd_data[BIT_MASK]  = ctrl_a.mask;
			rd_data[BIT_SENSE] = ctrl_a.sense;
		end else if (rd_idx == IDX_B_SC) begin
			rd_data[BIT_PEND]       = latch_r[1];
			rd_data[BIT_MASK]       = ctrl_b.mask;
			rd_data[BIT_SENSE]      = ctrl_b.sense;
			rd_data[BIT_PULLUP_DIS] = ctrl_b.pullup_dis;
		end else if (rd_idx == IDX_BREAK_CTRL) begin
			rd_data[BIT_BREAK_CLR_EN] = break_clr_en_r;
			rd_data[BIT_IN_BREAK]     = BREAK_STATE;
		end else if (rd_idx == IDX_IRQ_STATUS) begin
			rd_data[NUM_CHAN-1:0] = irq_status_r;
		end else if (rd_idx == IDX_IRQ_MASK) begin
			rd_data[NUM_CHAN-1:0] = irq_mask_r;
		end else if (rd_idx == IDX_PIN_LEVEL) begin
			rd_data[NUM_CHAN-1:0] = sync2_r;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= READ_ZERO;
			RRESP   <= RESP_OKAY;
		end else begin
			ARREADY <= !RVALID && !(ARVALID && ARREADY);
			if (ARVALID && ARREADY) begin
				RVALID  <= 1'b1;
				ARREADY <= 1'b0;
				RDATA   <= rd_data;
				RRESP   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// (R8) edge-mode software acknowledge clears the pending flag next cycle
	a_edge_ack_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R8
		(!sense_r[0] && sw_ack[0] && !fall[0]) |=> !latch_r[0])
		else $error("edge mode ack did not clear latch");

	// (R5) (R1) falling edge sets latch
	a_edge_sets_latch: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R5
		fall[1] |=> latch_r[1])
		else $error("falling edge did not set latch");

	// (R2) (R6) level mode holds while pin low
	a_level_holds_low: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R6
		(sense_r[0] && latch_r[0] && !sync2_r[0]) |=> latch_r[0])
		else $error("level latch dropped while pin low");

	sequence s_ack_then_high;
		(sense_r[1] && latch_r[1] && (ack_any[1] || ack_seen_r[1])
			&& !sync2_r[1] && !fall[1])
			##1 (sync2_r[1] && sense_r[1] && !fall[1]);
	endsequence
	// (R2) clear after acknowledge then pin high
	a_level_ack_first: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R2
		s_ack_then_high |=> !latch_r[1])
		else $error("level latch not cleared after ack and pin high");

	// (R15) break blocks acknowledge
	a_break_blocks: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R15
		(BREAK_STATE && !break_clr_en_r && latch_r[0] && !VECTOR_FETCH[0] && !ack_seen_r[0])
			|=> latch_r[0])
		else $error("ack taken in break with clear disabled");

	// (R18) request follows latch and mask
	a_req_mask: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R18
		INT_REQ == (latch_r & ~$past(mask_r)))
		else $error("request output does not match latch and mask");

	// (R3) vector fetch clears edge-mode latch
	a_vector_clear: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R3
		(VECTOR_FETCH[0] && !sense_r[0] && !fall[0]) |=> !latch_r[0])
		else $error("vector fetch did not clear latch");

	// (R17) edge detect needs high then low
	a_sync_edge: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R17
		fall[0] |-> ($past(sync2_r[0]) && !sync2_r[0]))
		else $error("edge flagged without high then low");

	// (R13) pin a pullup always on
	a_pullup_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R13
		PULLUP_EN[0] && (PULLUP_EN[1] == !$past(pullup_dis_r)))
		else $error("pullup output wrong");

endmodule

// ===== test/ext_pin_model.sv
// Behavioural model of the external devices on the two interrupt pins.
`timescale 1ns/1ps
module ext_pin_model (
	input  wire logic       clk,       // Bus clock.
	input  wire logic [1:0] drive_low, // Device pulls the pin low.
	input  wire logic [1:0] pullup_en, // Pullup state per pin.
	output logic      [1:0] pin_n      // Level on each pin.
);
	logic [1:0] float_r = 2'h0;

	// A released pin with no pullup has no defined level, so it wanders.
	always @(posedge clk) begin
		float_r <= ~float_r;
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pin_n[i] = drive_low[i] ? 1'h0 : (pullup_en[i] ? 1'h1 : float_r[i]);
		end
	end
endmodule

// ===== test/tb.sv
// Self-checking bench for the two-channel external interrupt latch.
`timescale 1ns/1ps
module tb;
	import ext_int_pkg::*;
	logic        CORE_CLK = 1'h0;
	logic        RST_N = 1'h0;
	logic        BREAK_STATE = 1'h0;
	logic        AWVALID = 1'h0;
	logic        WVALID = 1'h0;
	logic        BREADY = 1'h0;
	logic        ARVALID = 1'h0;
	logic        RREADY = 1'h0;
	logic [1:0]  VECTOR_FETCH = 2'h0;
	logic [1:0]  drv = 2'h0;
	logic [7:0]  AWADDR = 8'h0;
	logic [7:0]  ARADDR = 8'h0;
	logic [31:0] WDATA = 32'h0;
	logic [3:0]  WSTRB = 4'hf;
	logic [1:0]  EXT_INT_PIN_N, INT_REQ, PULLUP_EN, BRESP, RRESP, rs;
	logic        PIN_A_LEVEL, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [31:0] RDATA, rd;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	always #12.5 CORE_CLK = ~CORE_CLK;

	ext_pin_model i_ext_pin_model (.clk(CORE_CLK), .drive_low(drv), .pullup_en(PULLUP_EN),
		.pin_n(EXT_INT_PIN_N));

	ext_int_latch i_ext_int_latch (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
		.EXT_INT_PIN_N(EXT_INT_PIN_N), .VECTOR_FETCH(VECTOR_FETCH), .BREAK_STATE(BREAK_STATE),
		.INT_REQ(INT_REQ), .PIN_A_LEVEL(PIN_A_LEVEL), .PULLUP_EN(PULLUP_EN), .IRQ(IRQ),
		.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
		.RVALID(RVALID), .RREADY(RREADY));

	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CORE_CLK);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		@(posedge CORE_CLK);
		AWADDR <= idx << IDX_SHIFT;
		WDATA <= d;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge CORE_CLK);
			if (AWREADY && AWVALID) begin
				aw_ok = 1'h1;
				AWVALID <= 1'h0;
			end
			if (WREADY && WVALID) begin
				w_ok = 1'h1;
				WVALID <= 1'h0;
			end
		end
		while (BVALID !== 1'h1) @(posedge CORE_CLK);
		BREADY <= 1'h0;
		rs = BRESP;
		tick(2);
	endtask

	task automatic rdreg(input logic [7:0] idx);
		@(posedge CORE_CLK);
		ARADDR <= idx << IDX_SHIFT;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		do @(posedge CORE_CLK); while (ARREADY !== 1'h1);
		ARVALID <= 1'h0;
		while (RVALID !== 1'h1) @(posedge CORE_CLK);
		RREADY <= 1'h0;
		rd = RDATA;
		rs = RRESP;
	endtask

	task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
		rdreg(idx);
		check(rd, exp);
	endtask

	// Settling covers two sync flops, edge detect and the latch.
	task automatic pin(input logic [1:0] d);
		@(posedge CORE_CLK);
		drv <= d;
		tick(8);
	endtask

	always @(posedge CORE_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	initial begin
		tick(2);
		RST_N <= 1'h1;
		tick(3);
		check({PULLUP_EN, INT_REQ, PIN_A_LEVEL, IRQ}, 32'h32);
		rc(IDX_A_SC, 32'h0);
		rc(IDX_B_SC, 32'h0);
		rc(IDX_BREAK_CTRL, 32'h0);
		pin(2'h1);
		check(PIN_A_LEVEL, 32'h0);
		check(INT_REQ, 32'h1);
		rc(IDX_A_SC, 32'h8);
		wr(IDX_A_SC, 32'h4);
		check(rs, RESP_OKAY);
		rc(IDX_A_SC, 32'h0);
		check(INT_REQ, 32'h0);
		pin(2'h0);
		pin(2'h1);
		rc(IDX_A_SC, 32'h8);
		wr(IDX_A_SC, 32'h6);
		pin(2'h0);
		pin(2'h1);
		check(INT_REQ, 32'h0);
		rc(IDX_A_SC, 32'ha);
		@(posedge CORE_CLK) VECTOR_FETCH <= 2'h1;
		@(posedge CORE_CLK) VECTOR_FETCH <= 2'h0;
		tick(3);
		rc(IDX_A_SC, 32'h2);
		wr(IDX_A_SC, 32'h0);
		pin(2'h0);
		wr(IDX_B_SC, 32'h3);
		pin(2'h2);
		check(PIN_A_LEVEL, 32'h1);
		rc(IDX_PIN_LEVEL, 32'h1);
		wr(IDX_B_SC, 32'h7);
		rc(IDX_B_SC, 32'hb);
		pin(2'h0);
		rc(IDX_B_SC, 32'h3);
		pin(2'h2);
		pin(2'h0);
		rc(IDX_B_SC, 32'hb);
		wr(IDX_B_SC, 32'h7);
		rc(IDX_B_SC, 32'h3);
		wr(IDX_B_SC, 32'h0);
		@(posedge CORE_CLK) BREAK_STATE <= 1'h1;
		pin(2'h1);
		pin(2'h0);
		rc(IDX_BREAK_CTRL, 32'h2);
		wr(IDX_A_SC, 32'h4);
		rc(IDX_A_SC, 32'h8);
		wr(IDX_BREAK_CTRL, 32'h1);
		wr(IDX_A_SC, 32'h4);
		@(posedge CORE_CLK) BREAK_STATE <= 1'h0;
		tick(3);
		rc(IDX_A_SC, 32'h0);
		wr(IDX_BREAK_CTRL, 32'h0);
		wr(IDX_B_SC, 32'h10);
		check(PULLUP_EN, 32'h1);
		wr(IDX_B_SC, 32'h0);
		check(PULLUP_EN, 32'h3);
		tick(8);
		wr(IDX_B_SC, 32'h4);
		rc(IDX_B_SC, 32'h0);
		check(IRQ, 32'h1);
		rc(IDX_IRQ_STATUS, 32'h3);
		wr(IDX_IRQ_MASK, 32'h3);
		check(IRQ, 32'h0);
		wr(IDX_IRQ_MASK, 32'h1);
		check(IRQ, 32'h1);
		wr(IDX_IRQ_STATUS, 32'h3);
		check(IRQ, 32'h0);
		rc(IDX_IRQ_STATUS, 32'h0);
		wr(8'h10, 32'h1);
		check(rs, RESP_SLVERR);
		rc(8'h10, 32'h0);
		check(rs, RESP_SLVERR);
		wr(IDX_A_SC, 32'h1);
		pin(2'h1);
		check(INT_REQ, 32'h1);
		@(posedge CORE_CLK) RST_N <= 1'h0;
		tick(2);
		check(INT_REQ, 32'h0);
		RST_N <= 1'h1;
		tick(3);
		rdreg(IDX_A_SC);
		check(rd, 32'h0);
		check(INT_REQ, 32'h0);
		pin(2'h0);
		report_and_stop();
	end
endmodule
